// file: verilog/cfg_regs_pkg.sv
package cfg_regs_pkg;

  // ==========================================================================
  // Register offsets (byte addresses of the configuration space).
  // ==========================================================================
  localparam logic [11:0] OFF_MAX_NOSNOOP_LATENCY = 12'h0234;
  localparam logic [11:0] OFF_L1SS_CAP_HEADER = 12'h0240;
  localparam logic [11:0] OFF_L1SS_CAPABILITY = 12'h0244;
  localparam logic [11:0] OFF_L1SS_CONTROL_ONE = 12'h0248;
  localparam logic [11:0] OFF_L1SS_CONTROL_TWO = 12'h024C;
  localparam logic [11:0] OFF_LINK_TRAINING_STATUS = 12'h033C;
  localparam logic [11:0] OFF_HOT_INSERT_LINK_STATUS = 12'h0340;
  localparam logic [11:0] OFF_SERIAL_MGMT_CONTROL = 12'h0344;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int NSL_VALUE_LSB = 16;
  localparam int NSL_VALUE_MSB = 25;
  localparam int NSL_SCALE_LSB = 26;
  localparam int NSL_SCALE_MSB = 28;
  localparam int CAP_PM_L11_BIT = 1;
  localparam int CAP_ASPM_L11_BIT = 3;
  localparam int CAP_L1SS_BIT = 4;
  localparam int CTL_PM_L11_BIT = 1;
  localparam int CTL_ASPM_L11_BIT = 3;
  localparam int SMC_IF_SEL_BIT = 0;
  localparam int SMC_ADDR_LSB = 1;
  localparam int SMC_ADDR_MSB = 7;
  localparam int SMC_PEC_DIS_BIT = 9;
  localparam int SMC_PEC_FAIL_BIT = 29;
  localparam int SMC_UNSUP_BIT = 30;

  // ==========================================================================
  // Constant fields and reset values.
  // ==========================================================================
  localparam logic [15:0] L1SS_EXT_CAP_ID = 16'h001E;
  localparam logic [3:0] L1SS_CAP_VERSION = 4'h1;
  localparam logic [11:0] L1SS_NEXT_PTR = 12'h000;
  localparam logic [9:0] NSL_VALUE_RST = 10'h000;
  localparam logic [2:0] NSL_SCALE_RST = 3'h0;
  localparam logic CAP_PM_L11_RST = 1'b1;
  localparam logic CAP_ASPM_L11_RST = 1'b0;
  localparam logic CAP_L1SS_RST = 1'b1;
  localparam logic [7:0] LTS_RST = 8'h00;
  localparam logic [15:0] HOT_INSERT_RST = 16'h0000;
  localparam logic [15:0] LINK_STATUS_ONE_RST = 16'h0004;
  localparam logic IF_SEL_RST = 1'b1;
  localparam logic [3:0] ADDR_UPPER_RST = 4'hD;
  localparam logic PEC_DIS_RST = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// file: verilog/w1c_flag.sv
`timescale 1ns/1ns
module w1c_flag
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);

  typedef struct packed {
    logic flag;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ==========================================================================
  // Sticky flag: a set in the same cycle as a clear wins, so no event is lost.
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    if (set_i)
    begin
      state_next.flag = 1'b1;
    end
    else if (clear_i)
    begin
      state_next.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign flag_o = state_reg.flag;

endmodule

// file: verilog/lpm_substates_smbus_cfg_regs.sv
// Overview of operation
// - A 10-bit read-write no-snoop latency value sits in bits 25:16 of the latency register, reset to zero.
// - A 3-bit read-write scale sits in bits 28:26, reset to zero, with bits 31:29 reserved.
// - The substates header returns capability identifier 001Eh in bits 15:0 and version 1h in bits 19:16.
// - The next-capability pointer in header bits 31:20 reads zero, ending the capability list.
// - Capability bit 1 reports L1.1 under power management, default one, replaceable by preload.
// - Capability bit 3 reports active-state L1.1, default zero, replaceable by preload.
// - Capability bit 4 reports L1 substates support, default one, replaceable by preload.
// - Control bit 1 is a read-write enable for power-management L1.1, reset to zero.
// - Control bit 3 is a read-write enable for active-state L1.1, reset to zero.
// - The second substates control register is read-only and always reads zero.
// - Serial control bit 0 selects SMBus when one and I2C when zero, reset to one.
// - Serial control bits 7:1 hold the target address, upper four bits 1101b, lower three from straps.
// - Serial control bit 9 disables packet error checking when one, reset to one.
// - Serial control bit 29 is a sticky write-one-to-clear flag set on a failed packet error check while bit 9 is zero.
// - Serial control bit 30 is a sticky write-one-to-clear flag set on an unsupported command.
`timescale 1ns/1ns
module lpm_substates_smbus_cfg_regs
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_hit_o,
  input wire logic preload_i,
  input wire logic [11:0] preload_addr_i,
  input wire logic [31:0] preload_data_i,
  input wire logic [2:0] addr_strap_i,
  input wire logic pec_check_i,
  input wire logic pec_bad_i,
  input wire logic unsup_cmd_i,
  output logic nosnoop_value_o,
  output logic [9:0] nosnoop_latency_o,
  output logic [2:0] nosnoop_scale_o,
  output logic pm_l11_en_o,
  output logic aspm_l11_en_o,
  output logic smbus_sel_o,
  output logic [6:0] target_addr_o,
  output logic pec_disable_o
);

  // The whole bank lives in one struct; the two sticky flags sit in cells of their own.
  typedef struct packed {
    logic [9:0] nsl_value;
    logic [2:0] nsl_scale;
    logic nsl_nonzero;
    logic cap_pm_l11;
    logic cap_aspm_l11;
    logic cap_l1ss;
    logic ctl_pm_l11;
    logic ctl_aspm_l11;
    logic [7:0] lts;
    logic [15:0] hot_insert;
    logic [15:0] link_status_one;
    logic if_sel;
    logic [6:0] target_addr;
    logic pec_dis;
    logic strap_taken;
    logic [31:0] rdata;
    logic hit;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic pec_fail;
  logic unsup_flag;
  logic pec_fail_set;
  logic pec_fail_clr;
  logic unsup_clr;
  logic wr_serial;

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Byte lanes left disabled keep their old contents.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Mapped offsets answer with hit, the read-only ones included.
  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      cfg_regs_pkg::OFF_MAX_NOSNOOP_LATENCY,
      cfg_regs_pkg::OFF_L1SS_CAP_HEADER,
      cfg_regs_pkg::OFF_L1SS_CAPABILITY,
      cfg_regs_pkg::OFF_L1SS_CONTROL_ONE,
      cfg_regs_pkg::OFF_L1SS_CONTROL_TWO,
      cfg_regs_pkg::OFF_LINK_TRAINING_STATUS,
      cfg_regs_pkg::OFF_HOT_INSERT_LINK_STATUS,
      cfg_regs_pkg::OFF_SERIAL_MGMT_CONTROL:
      begin
        hit = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ==========================================================================
  // Sticky error flags.
  // ==========================================================================
  // A clear needs the byte lane that holds the flag, so writes to the lower lanes leave both flags alone.
  function automatic logic w1c_hit(input logic wr, input logic [3:0] be, input logic [31:0] d, input int pos);
    return wr && be[pos / 8] && d[pos];
  endfunction

  assign wr_serial = cfg_wr_i && (cfg_addr_i == cfg_regs_pkg::OFF_SERIAL_MGMT_CONTROL);
  assign pec_fail_set = pec_check_i && pec_bad_i && !state_reg.pec_dis;
  assign pec_fail_clr = w1c_hit(wr_serial, cfg_be_i, cfg_wdata_i, cfg_regs_pkg::SMC_PEC_FAIL_BIT);
  assign unsup_clr = w1c_hit(wr_serial, cfg_be_i, cfg_wdata_i, cfg_regs_pkg::SMC_UNSUP_BIT);

  // Set beats clear inside each cell, so an error that lands on the clearing write is kept.
  w1c_flag u_pec_fail
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(pec_fail_set),
    .clear_i(pec_fail_clr),
    .flag_o(pec_fail)
  );

  w1c_flag u_unsup_cmd
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(unsup_cmd_i),
    .clear_i(unsup_clr),
    .flag_o(unsup_flag)
  );

  // ==========================================================================
  // Register image and read data.
  // ==========================================================================
  // One decoder serves both the read answer and the read-modify-write merge.
  function automatic logic [31:0] read_word(input state_s s, input logic [11:0] a, input logic pf, input logic uf);
    logic [31:0] w;
    // Every bit not filled in below is reserved and reads zero.
    w = cfg_regs_pkg::ZERO_WORD;
    case (a)
      cfg_regs_pkg::OFF_MAX_NOSNOOP_LATENCY:
      begin
        w[cfg_regs_pkg::NSL_VALUE_MSB:cfg_regs_pkg::NSL_VALUE_LSB] = s.nsl_value;
        w[cfg_regs_pkg::NSL_SCALE_MSB:cfg_regs_pkg::NSL_SCALE_LSB] = s.nsl_scale;
      end
      cfg_regs_pkg::OFF_L1SS_CAP_HEADER:
      begin
        w = {cfg_regs_pkg::L1SS_NEXT_PTR, cfg_regs_pkg::L1SS_CAP_VERSION, cfg_regs_pkg::L1SS_EXT_CAP_ID};
      end
      cfg_regs_pkg::OFF_L1SS_CAPABILITY:
      begin
        w[cfg_regs_pkg::CAP_PM_L11_BIT] = s.cap_pm_l11;
        w[cfg_regs_pkg::CAP_ASPM_L11_BIT] = s.cap_aspm_l11;
        w[cfg_regs_pkg::CAP_L1SS_BIT] = s.cap_l1ss;
      end
      cfg_regs_pkg::OFF_L1SS_CONTROL_ONE:
      begin
        w[cfg_regs_pkg::CTL_PM_L11_BIT] = s.ctl_pm_l11;
        w[cfg_regs_pkg::CTL_ASPM_L11_BIT] = s.ctl_aspm_l11;
      end
      cfg_regs_pkg::OFF_L1SS_CONTROL_TWO:
      begin
        w = cfg_regs_pkg::ZERO_WORD;
      end
      cfg_regs_pkg::OFF_LINK_TRAINING_STATUS:
      begin
        w[7:0] = s.lts;
      end
      cfg_regs_pkg::OFF_HOT_INSERT_LINK_STATUS:
      begin
        // Two 16-bit status halves share this one offset.
        w = {s.link_status_one, s.hot_insert};
      end
      cfg_regs_pkg::OFF_SERIAL_MGMT_CONTROL:
      begin
        w[cfg_regs_pkg::SMC_IF_SEL_BIT] = s.if_sel;
        w[cfg_regs_pkg::SMC_ADDR_MSB:cfg_regs_pkg::SMC_ADDR_LSB] = s.target_addr;
        w[cfg_regs_pkg::SMC_PEC_DIS_BIT] = s.pec_dis;
        w[cfg_regs_pkg::SMC_PEC_FAIL_BIT] = pf;
        w[cfg_regs_pkg::SMC_UNSUP_BIT] = uf;
      end
      default:
      begin
        w = cfg_regs_pkg::ZERO_WORD;
      end
    endcase
    return w;
  endfunction

  // ==========================================================================
  // Next state: configuration writes, then preload, which wins on a clash.
  // ==========================================================================
  always_comb
  begin
    logic [31:0] m;
    logic [31:0] p;
    m = cfg_regs_pkg::ZERO_WORD;
    p = preload_data_i;
    state_next = state_reg;

    // The low address bits come from straps, which are only valid after reset is released.
    if (!state_reg.strap_taken)
    begin
      state_next.strap_taken = 1'b1;
      state_next.target_addr[2:0] = addr_strap_i;
    end

    if (cfg_wr_i)
    begin
      m = merge_bytes(read_word(state_reg, cfg_addr_i, pec_fail, unsup_flag), cfg_wdata_i, cfg_be_i);
      case (cfg_addr_i)
        cfg_regs_pkg::OFF_MAX_NOSNOOP_LATENCY:
        begin
          state_next.nsl_value = m[cfg_regs_pkg::NSL_VALUE_MSB:cfg_regs_pkg::NSL_VALUE_LSB];
          state_next.nsl_scale = m[cfg_regs_pkg::NSL_SCALE_MSB:cfg_regs_pkg::NSL_SCALE_LSB];
        end
        cfg_regs_pkg::OFF_L1SS_CONTROL_ONE:
        begin
          state_next.ctl_pm_l11 = m[cfg_regs_pkg::CTL_PM_L11_BIT];
          state_next.ctl_aspm_l11 = m[cfg_regs_pkg::CTL_ASPM_L11_BIT];
        end
        cfg_regs_pkg::OFF_SERIAL_MGMT_CONTROL:
        begin
          // A write may replace all seven address bits, strap bits included.
          state_next.if_sel = m[cfg_regs_pkg::SMC_IF_SEL_BIT];
          state_next.target_addr = m[cfg_regs_pkg::SMC_ADDR_MSB:cfg_regs_pkg::SMC_ADDR_LSB];
          state_next.pec_dis = m[cfg_regs_pkg::SMC_PEC_DIS_BIT];
        end
        default:
        begin
          state_next.hit = state_reg.hit;
        end
      endcase
    end

    // Preload carries the read-only defaults; of the writable fields only the interface select and target address take it too.
    if (preload_i)
    begin
      case (preload_addr_i)
        cfg_regs_pkg::OFF_L1SS_CAPABILITY:
        begin
          state_next.cap_pm_l11 = p[cfg_regs_pkg::CAP_PM_L11_BIT];
          state_next.cap_aspm_l11 = p[cfg_regs_pkg::CAP_ASPM_L11_BIT];
          state_next.cap_l1ss = p[cfg_regs_pkg::CAP_L1SS_BIT];
        end
        cfg_regs_pkg::OFF_LINK_TRAINING_STATUS:
        begin
          state_next.lts = p[7:0];
        end
        cfg_regs_pkg::OFF_HOT_INSERT_LINK_STATUS:
        begin
          state_next.hot_insert = p[15:0];
          state_next.link_status_one = p[31:16];
        end
        cfg_regs_pkg::OFF_SERIAL_MGMT_CONTROL:
        begin
          // The check disable and the sticky flags are not preloaded; they always start from reset.
          state_next.if_sel = p[cfg_regs_pkg::SMC_IF_SEL_BIT];
          state_next.target_addr = p[cfg_regs_pkg::SMC_ADDR_MSB:cfg_regs_pkg::SMC_ADDR_LSB];
        end
        default:
        begin
          state_next.hit = state_reg.hit;
        end
      endcase
    end

    // Keeping the nonzero flag in a flop keeps a ten-input gate off the output path.
    state_next.nsl_nonzero = |state_next.nsl_value;
    // Read data is zero outside its answer cycle, so a stale word is never taken for an answer.
    state_next.hit = (cfg_rd_i || cfg_wr_i) && is_mapped(cfg_addr_i);
    state_next.rdata = cfg_regs_pkg::ZERO_WORD;
    if (cfg_rd_i)
    begin
      state_next.rdata = read_word(state_reg, cfg_addr_i, pec_fail, unsup_flag);
    end
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= '0;
      state_reg.nsl_value <= cfg_regs_pkg::NSL_VALUE_RST;
      state_reg.nsl_scale <= cfg_regs_pkg::NSL_SCALE_RST;
      state_reg.cap_pm_l11 <= cfg_regs_pkg::CAP_PM_L11_RST;
      state_reg.cap_aspm_l11 <= cfg_regs_pkg::CAP_ASPM_L11_RST;
      state_reg.cap_l1ss <= cfg_regs_pkg::CAP_L1SS_RST;
      state_reg.lts <= cfg_regs_pkg::LTS_RST;
      state_reg.hot_insert <= cfg_regs_pkg::HOT_INSERT_RST;
      state_reg.link_status_one <= cfg_regs_pkg::LINK_STATUS_ONE_RST;
      state_reg.if_sel <= cfg_regs_pkg::IF_SEL_RST;
      // The strap bits stay zero here; the first edge after release fills them in.
      state_reg.target_addr <= {cfg_regs_pkg::ADDR_UPPER_RST, 3'b000};
      state_reg.pec_dis <= cfg_regs_pkg::PEC_DIS_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  // Every output comes straight from a flop, so downstream logic sees clean levels.
  assign cfg_rdata_o = state_reg.rdata;
  assign cfg_hit_o = state_reg.hit;
  assign nosnoop_value_o = state_reg.nsl_nonzero;
  assign nosnoop_latency_o = state_reg.nsl_value;
  assign nosnoop_scale_o = state_reg.nsl_scale;
  assign pm_l11_en_o = state_reg.ctl_pm_l11;
  assign aspm_l11_en_o = state_reg.ctl_aspm_l11;
  assign smbus_sel_o = state_reg.if_sel;
  assign target_addr_o = state_reg.target_addr;
  assign pec_disable_o = state_reg.pec_dis;

endmodule

// file: tb/cfg_regs_monitor.sv
`timescale 1ns/1ns
module cfg_regs_monitor
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_hit_o,
  input wire logic preload_i,
  input wire logic [9:0] nosnoop_latency_o,
  input wire logic [2:0] nosnoop_scale_o,
  input wire logic pm_l11_en_o,
  input wire logic aspm_l11_en_o,
  input wire logic smbus_sel_o,
  input wire logic [6:0] target_addr_o,
  input wire logic pec_disable_o
);
  // ==========================================================================
  // Register checks.
  // ==========================================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic wr_ok;
  assign wr_ok = cfg_wr_i && !preload_i;

  a_header_read: assert property (
    cfg_rd_i && cfg_addr_i == 12'h0240 |=> cfg_hit_o && cfg_rdata_o == 32'h0001_001E)
    else $error("header read wrong");
  a_ctl_two_zero: assert property (
    cfg_rd_i && cfg_addr_i == 12'h024C |=> cfg_rdata_o == 32'h0000_0000)
    else $error("second control not zero");
  a_latency_write: assert property (
    wr_ok && cfg_addr_i == 12'h0234 && cfg_be_i[3:2] == 2'b11
    |=> nosnoop_latency_o == $past(cfg_wdata_i[25:16]))
    else $error("latency value not written");
  a_scale_write: assert property (
    wr_ok && cfg_addr_i == 12'h0234 && cfg_be_i[3] |=> nosnoop_scale_o == $past(cfg_wdata_i[28:26]))
    else $error("latency scale not written");
  a_enable_write: assert property (
    wr_ok && cfg_addr_i == 12'h0248 && cfg_be_i[0]
    |=> {pm_l11_en_o, aspm_l11_en_o} == {$past(cfg_wdata_i[1]), $past(cfg_wdata_i[3])})
    else $error("substate enables not written");
  a_select_write: assert property (
    wr_ok && cfg_addr_i == 12'h0344 && cfg_be_i[0]
    |=> {target_addr_o, smbus_sel_o} == $past(cfg_wdata_i[7:0]))
    else $error("serial select or address not written");
  a_pec_write: assert property (
    wr_ok && cfg_addr_i == 12'h0344 && cfg_be_i[1] |=> pec_disable_o == $past(cfg_wdata_i[9]))
    else $error("packet check disable not written");
  a_serial_read: assert property (
    cfg_rd_i && cfg_addr_i == 12'h0344 |=> cfg_rdata_o[9:0] ==
    {$past(pec_disable_o), 1'b0, $past(target_addr_o), $past(smbus_sel_o)}
    && cfg_rdata_o[28:10] == 19'h0_0000 && !cfg_rdata_o[31])
    else $error("serial control read wrong");
  a_unmapped_read: assert property (
    cfg_rd_i && cfg_addr_i == 12'h0100 |=> !cfg_hit_o && cfg_rdata_o == 32'h0000_0000)
    else $error("unmapped read answered");
endmodule

// file: tb/mgmt_host_model.sv
`timescale 1ns/1ns
module mgmt_host_model
(
  input wire logic clk_i,
  output logic preload_o,
  output logic [11:0] preload_addr_o,
  output logic [31:0] preload_data_o,
  output logic pec_check_o,
  output logic pec_bad_o,
  output logic unsup_cmd_o
);
  // ==========================================================================
  // Management host events.
  // ==========================================================================
  initial
  begin
    preload_o = 1'b0;
    preload_addr_o = 12'h0000;
    preload_data_o = 32'h0000_0000;
    pec_check_o = 1'b0;
    pec_bad_o = 1'b0;
    unsup_cmd_o = 1'b0;
  end

  // Released data lines show the inverse so that stale values are never trusted; the preload address keeps its value.
  task load(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_i);
    preload_o = 1'b1;
    preload_addr_o = a;
    preload_data_o = d;
    @(negedge clk_i);
    preload_o = 1'b0;
    preload_data_o = ~d;
  endtask

  task check(input logic bad);
    @(negedge clk_i);
    pec_check_o = 1'b1;
    pec_bad_o = bad;
    @(negedge clk_i);
    pec_check_o = 1'b0;
    pec_bad_o = ~bad;
  endtask

  task unsup;
    @(negedge clk_i);
    unsup_cmd_o = 1'b1;
    @(negedge clk_i);
    unsup_cmd_o = 1'b0;
  endtask
endmodule

// file: tb/lpm_substates_smbus_cfg_regs_tb.sv
`timescale 1ns/1ns
module lpm_substates_smbus_cfg_regs_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [11:0] cfg_addr_i = 12'h0000;
  logic [3:0] cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0000_0000;
  logic [2:0] addr_strap_i = 3'h5;
  logic [31:0] cfg_rdata_o, preload_data_i;
  logic [11:0] preload_addr_i;
  logic [9:0] nosnoop_latency_o;
  logic [2:0] nosnoop_scale_o;
  logic [6:0] target_addr_o;
  logic cfg_hit_o, preload_i, pec_check_i, pec_bad_i, unsup_cmd_i, nosnoop_value_o, pm_l11_en_o;
  logic aspm_l11_en_o, smbus_sel_o, pec_disable_o;
  int fail_count = 0;
  int n_checks = 0;

  always #25 clk_i = ~clk_i;

  lpm_substates_smbus_cfg_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o), .preload_i(preload_i), .preload_addr_i(preload_addr_i),
    .preload_data_i(preload_data_i), .addr_strap_i(addr_strap_i), .pec_check_i(pec_check_i),
    .pec_bad_i(pec_bad_i), .unsup_cmd_i(unsup_cmd_i), .nosnoop_value_o(nosnoop_value_o),
    .nosnoop_latency_o(nosnoop_latency_o), .nosnoop_scale_o(nosnoop_scale_o), .pm_l11_en_o(pm_l11_en_o),
    .aspm_l11_en_o(aspm_l11_en_o), .smbus_sel_o(smbus_sel_o), .target_addr_o(target_addr_o),
    .pec_disable_o(pec_disable_o));

  mgmt_host_model host (.clk_i(clk_i), .preload_o(preload_i), .preload_addr_o(preload_addr_i),
    .preload_data_o(preload_data_i), .pec_check_o(pec_check_i), .pec_bad_o(pec_bad_i),
    .unsup_cmd_o(unsup_cmd_i));

  // ==========================================================================
  // Bus tasks.
  // ==========================================================================
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_be_i = be;
    cfg_wdata_i = d;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
  endtask

  task rdchk(input string n, input logic [11:0] a, input logic [31:0] e, input logic h);
    @(negedge clk_i);
    cfg_rd_i = 1'b1;
    cfg_addr_i = a;
    @(negedge clk_i);
    cfg_rd_i = 1'b0;
    chk(n, e, cfg_rdata_o);
    chk("hit", {31'h0, h}, {31'h0, cfg_hit_o});
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task t_reset;
    rdchk("latency", 12'h0234, 32'h0000_0000, 1'b1);
    rdchk("header", 12'h0240, 32'h0001_001E, 1'b1);
    rdchk("capability", 12'h0244, 32'h0000_0012, 1'b1);
    rdchk("control one", 12'h0248, 32'h0000_0000, 1'b1);
    rdchk("control two", 12'h024C, 32'h0000_0000, 1'b1);
    rdchk("training", 12'h033C, 32'h0000_0000, 1'b1);
    rdchk("hot insert", 12'h0340, 32'h0004_0000, 1'b1);
    rdchk("serial", 12'h0344, 32'h0000_02DB, 1'b1);
    $display("test reset done");
  endtask

  task t_latency;
    wr(12'h0234, 4'hF, 32'hFFFF_FFFF);
    rdchk("latency", 12'h0234, 32'h1FFF_0000, 1'b1);
    chk("value", 32'h0000_03FF, {22'h0, nosnoop_latency_o});
    chk("scale", 32'h0000_0007, {29'h0, nosnoop_scale_o});
    chk("nonzero", 32'h0000_0001, {31'h0, nosnoop_value_o});
    wr(12'h0234, 4'h4, 32'h0000_0000);
    rdchk("latency lane", 12'h0234, 32'h1F00_0000, 1'b1);
    $display("test latency done");
  endtask

  task t_readonly;
    wr(12'h0240, 4'hF, 32'hFFFF_FFFF);
    wr(12'h024C, 4'hF, 32'hFFFF_FFFF);
    wr(12'h0340, 4'hF, 32'hFFFF_FFFF);
    rdchk("header", 12'h0240, 32'h0001_001E, 1'b1);
    rdchk("control two", 12'h024C, 32'h0000_0000, 1'b1);
    rdchk("hot insert", 12'h0340, 32'h0004_0000, 1'b1);
    wr(12'h0100, 4'hF, 32'hFFFF_FFFF);
    rdchk("unmapped", 12'h0100, 32'h0000_0000, 1'b0);
    $display("test read only done");
  endtask

  task t_control;
    wr(12'h0248, 4'hF, 32'hFFFF_FFFF);
    rdchk("control one", 12'h0248, 32'h0000_000A, 1'b1);
    wr(12'h0248, 4'hF, 32'h0000_0008);
    chk("enables", 32'h0000_0001, {30'h0, pm_l11_en_o, aspm_l11_en_o});
    host.load(12'h0244, 32'h0000_0008);
    rdchk("capability", 12'h0244, 32'h0000_0008, 1'b1);
    $display("test control done");
  endtask

  task t_serial;
    wr(12'h0344, 4'h3, 32'h0000_0034);
    chk("select", 32'h0000_0000, {31'h0, smbus_sel_o});
    chk("target", 32'h0000_001A, {25'h0, target_addr_o});
    chk("pec off", 32'h0000_0000, {31'h0, pec_disable_o});
    host.check(1'b1);
    host.unsup();
    rdchk("flags", 12'h0344, 32'h6000_0034, 1'b1);
    wr(12'h0344, 4'h7, 32'h6000_0034);
    rdchk("lane kept", 12'h0344, 32'h6000_0034, 1'b1);
    wr(12'h0344, 4'h8, 32'h2000_0000);
    rdchk("clear one", 12'h0344, 32'h4000_0034, 1'b1);
    wr(12'h0344, 4'h8, 32'h4000_0000);
    host.check(1'b0);
    rdchk("clear two", 12'h0344, 32'h0000_0034, 1'b1);
    fork
      wr(12'h0344, 4'h8, 32'h2000_0000);
      host.check(1'b1);
    join
    rdchk("set wins", 12'h0344, 32'h2000_0034, 1'b1);
    wr(12'h0344, 4'hA, 32'h2000_0200);
    host.check(1'b1);
    rdchk("disabled", 12'h0344, 32'h0000_0234, 1'b1);
    $display("test serial done");
  endtask

  task t_rerun;
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    addr_strap_i = 3'h2;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rdchk("serial", 12'h0344, 32'h0000_02D5, 1'b1);
    rdchk("capability", 12'h0244, 32'h0000_0012, 1'b1);
    rdchk("latency", 12'h0234, 32'h0000_0000, 1'b1);
    chk("enables", 32'h0000_0000, {30'h0, pm_l11_en_o, aspm_l11_en_o});
    chk("nonzero", 32'h0000_0000, {31'h0, nosnoop_value_o});
    $display("test reset rerun done");
  endtask

  task stop_test;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end

  initial
  begin
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_latency();
    t_readonly();
    t_control();
    t_serial();
    t_rerun();
    stop_test();
  end
endmodule

bind lpm_substates_smbus_cfg_regs cfg_regs_monitor mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i),
  .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o), .preload_i(preload_i), .nosnoop_latency_o(nosnoop_latency_o),
  .nosnoop_scale_o(nosnoop_scale_o), .pm_l11_en_o(pm_l11_en_o), .aspm_l11_en_o(aspm_l11_en_o),
  .smbus_sel_o(smbus_sel_o), .target_addr_o(target_addr_o), .pec_disable_o(pec_disable_o));
